// [core/irq_priority_ctrl.sv]
/*
  interrupt enable, flag, sharing and four-level priority arbitration
  for an 8051-class core. the core sees one request with a source
  number and a level; it pulses ack_i when it enters the handler and
  ret_i on return from interrupt. peripheral and compare events are
  one-cycle pulses on clk_i; the two external pins are asynchronous.
  assumes a classic wishbone master that holds its request until ack
  and leaves one idle cycle between transfers; registers sit at byte
  address four times their index, one byte per word in bits 7:0.
  assumes the core pulses ack_i only while irq_o stands, and that it
  pulses ret_i once for every handler it entered, innermost first.
  the uart sources are levels kept by the uarts themselves, so they
  have no flag here and software clears them at the uart.
*/
// Overview of operation
// - ien1 bit2 spi receive, bit1 transmit enables
// - irq_enable_third bit0 enables second uart
// - four channels shared with compare units
// - compare mode routes compare, blocks peripheral
// - takeover applies per compare unit
// - request flag register bit layout
// - reload flag set only when enabled
// - four levels, three highest, per group
// - six groups pair sources as listed
// - level is high bit, low bit
// - zero priority gives natural order
// - watchdog overflow sets sticky status bit
// - spare bit is plain storage
// - type zero low level, one falling
// - edge-mode external flag auto-clears on service
// - external flags bits 3,1; types 2,0
// - timer overflow flags, sw/hw clear
// - run bits start and stop timers
// - global gate masks all enabled interrupts
`timescale 1ns/1ps
module irq_priority_ctrl
  import irq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic external_irq_a_pin_i,
  input wire logic external_irq_b_pin_i,
  input wire logic timer0_ovf_i,
  input wire logic timer1_ovf_i,
  input wire logic timer2_ovf_i,
  input wire logic timer2_reload_i,
  input wire logic uart0_irq_i,
  input wire logic uart1_irq_i,
  input wire logic spi_rx_i,
  input wire logic spi_tx_i,
  input wire logic i2c_i,
  input wire logic mac_ovf_i,
  input wire logic adc_i,
  input wire logic [3:0] compare_i,
  input wire logic watchdog_ovf_i,
  input wire logic ack_i,
  input wire logic ret_i,
  output logic irq_o,
  output logic [3:0] irq_src_o,
  output logic [1:0] irq_level_o,
  output logic timer_zero_run_o,
  output logic timer_one_run_o
);
  logic [7:0] timer_and_external_irq_control_q, irq_request_flags_q, ien0_q, ien1_q, irq_enable_third_q, ip0_q, ip1_q;
  logic [7:0] compare_capture_enable_config_q;
  logic [1:0] pin_a_q, pin_b_q;
  logic pin_a_prev_q, pin_b_prev_q;
  logic [3:0] active_q;
  logic [3:0] top_src_q;
  logic [1:0] top_lvl_q;
  logic [1:0] run_lvl_q;
  logic req_q, ack_q;
  logic [num_src-1:0] pend, en;
  logic [1:0] lvl [num_src];
  logic [3:0] best_src;
  logic [1:0] best_lvl;
  logic best_any;
  logic [3:0] take_over;
  logic access, wr;
  logic [7:0] idx;
  logic [7:0] wdat;
  logic a_fall, b_fall, a_low, b_low;
  logic [3:0] srv_src;

  // bus decode: byte address is four times the register index
  assign idx = adr_i[9:2];
  assign access = cyc_i & stb_i & ~ack_q;
  assign wr = access & we_i & sel_i[0];
  assign wdat = dat_i[7:0];
  // the handler entry strobe names the source being serviced
  assign srv_src = ack_i ? top_src_q : no_source;

  // two-flop synchronisers on the external pins
  // only the second stage feeds logic, so a metastable first stage
  // never reaches the flag logic; the edge stage resets to the idle
  // high level so release of reset cannot fake a falling edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_a_q <= 2'b11;
      pin_b_q <= 2'b11;
      pin_a_prev_q <= 1'b1;
      pin_b_prev_q <= 1'b1;
    end else begin
      pin_a_q <= {pin_a_q[0], external_irq_a_pin_i};
      pin_b_q <= {pin_b_q[0], external_irq_b_pin_i};
      pin_a_prev_q <= pin_a_q[1];
      pin_b_prev_q <= pin_b_q[1];
    end
  end

  assign a_fall = pin_a_prev_q & ~pin_a_q[1];
  assign b_fall = pin_b_prev_q & ~pin_b_q[1];
  assign a_low = ~pin_a_q[1];
  assign b_low = ~pin_b_q[1];

  // compare mode takes over; one unit per channel
  // unit k is in compare mode when its config bit 2k is set; each
  // unit steals only its own shared channel, the other three keep
  // their peripheral source and their own enable bit
  assign take_over = {compare_capture_enable_config_q[6], compare_capture_enable_config_q[4], compare_capture_enable_config_q[2], compare_capture_enable_config_q[0]};

  // timer control register; set beats clear in the same cycle
  // order matters below: software write first, then service clears,
  // then hardware sets, so an event landing with a clear is not lost
  // level-mode flags are not latched: they follow the synced pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_and_external_irq_control_q <= reg_reset;
    end else begin
      logic [7:0] nx;
      nx = timer_and_external_irq_control_q;
      // run bits and types are software storage
      if (wr && idx == timer_ctrl_idx) nx = wdat;
      if (srv_src == 4'(src_ext_a) && timer_and_external_irq_control_q[external_irq_a_type_bit])
        nx[external_irq_a_flag_bit] = 1'b0;
      if (srv_src == 4'(src_ext_b) && timer_and_external_irq_control_q[external_irq_b_type_bit])
        nx[external_irq_b_flag_bit] = 1'b0;
      if (srv_src == 4'(src_timer0)) nx[timer_zero_overflow_bit] = 1'b0;
      if (srv_src == 4'(src_timer1)) nx[timer_one_overflow_bit] = 1'b0;
      if (timer0_ovf_i) nx[timer_zero_overflow_bit] = 1'b1;
      if (timer1_ovf_i) nx[timer_one_overflow_bit] = 1'b1;
      // level mode follows the pin, edge mode latches
      if (timer_and_external_irq_control_q[external_irq_a_type_bit]) begin
        if (a_fall) nx[external_irq_a_flag_bit] = 1'b1;
      end else begin
        nx[external_irq_a_flag_bit] = a_low;
      end
      if (timer_and_external_irq_control_q[external_irq_b_type_bit]) begin
        if (b_fall) nx[external_irq_b_flag_bit] = 1'b1;
      end else begin
        nx[external_irq_b_flag_bit] = b_low;
      end
      timer_and_external_irq_control_q <= nx;
    end
  end

  // request flags: layout, cleared by software writes
  // these flags are never cleared by service, since several events
  // share one vector and only software knows which one it handled
  // bit 0 is reserved and always reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_request_flags_q <= reg_reset;
    end else begin
      logic [7:0] nx;
      nx = irq_request_flags_q;
      if (wr && idx == req_flags_idx) nx = wdat & 8'hfe;
      if (timer2_reload_i && ien1_q[timer2_reload_irq_enable_bit])
        nx[timer2_reload_flag_bit] = 1'b1;
      if (timer2_ovf_i) nx[timer2_overflow_flag_bit] = 1'b1;
      // each shared flag takes peripheral or compare event
      if (take_over[3] ? compare_i[3] : adc_i)
        nx[converter_request_flag_bit] = 1'b1;
      if (take_over[2] ? compare_i[2] : mac_ovf_i)
        nx[multiply_accumulate_flag_bit] = 1'b1;
      if (take_over[1] ? compare_i[1] : i2c_i)
        nx[two_wire_request_flag_bit] = 1'b1;
      if (take_over[0] ? compare_i[0] : spi_rx_i)
        nx[spi_receive_flag_bit] = 1'b1;
      if (spi_tx_i) nx[spi_transmit_empty_flag_bit] = 1'b1;
      irq_request_flags_q <= nx;
    end
  end

  // plain enable and compare configuration storage
  // reserved bits of ien1, irq_enable_third and ip1 are masked on write so they always read back zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ien0_q <= reg_reset;
      ien1_q <= reg_reset;
      irq_enable_third_q <= reg_reset;
      ip1_q <= reg_reset;
      compare_capture_enable_config_q <= reg_reset;
    end else if (wr) begin
      if (idx == enable_zero_idx) ien0_q <= wdat;
      if (idx == enable_one_idx) ien1_q <= wdat & 8'hfe;
      if (idx == enable_third_idx) irq_enable_third_q <= wdat & 8'h01;
      if (idx == prio_high_idx) ip1_q <= wdat & 8'h3f;
      if (idx == compare_cfg_idx) compare_capture_enable_config_q <= wdat;
    end
  end

  // priority register zero: spare bit, sticky watchdog bit
  // a software clear in the overflow cycle loses to the overflow
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ip0_q <= reg_reset;
    end else begin
      logic [7:0] nx;
      nx = ip0_q;
      if (wr && idx == prio_low_idx) nx = wdat;
      if (watchdog_ovf_i) nx[watchdog_overflow_status_bit] = 1'b1;
      ip0_q <= nx;
    end
  end

  // pending and enable per source, natural order
  // the index of each source is its natural rank, so the arbiter
  // below only needs a strict greater-than to keep ties in order
  always_comb begin
    pend = '0;
    en = '0;
    pend[src_ext_a] = timer_and_external_irq_control_q[external_irq_a_flag_bit];
    en[src_ext_a] = ien0_q[0];
    pend[src_uart1] = uart1_irq_i;
    en[src_uart1] = irq_enable_third_q[second_uart_irq_enable_bit];
    pend[src_timer0] = timer_and_external_irq_control_q[timer_zero_overflow_bit];
    en[src_timer0] = ien0_q[1];
    pend[src_spi_tx] = irq_request_flags_q[spi_transmit_empty_flag_bit];
    en[src_spi_tx] = ien1_q[spi_transmit_empty_irq_enable_bit];
    pend[src_ext_b] = timer_and_external_irq_control_q[external_irq_b_flag_bit];
    en[src_ext_b] = ien0_q[2];
    pend[src_spi_rx] = irq_request_flags_q[spi_receive_flag_bit];
    // compare mode ignores the peripheral enable
    en[src_spi_rx] = take_over[0] |
                     ien1_q[spi_receive_irq_enable_bit];
    pend[src_timer1] = timer_and_external_irq_control_q[timer_one_overflow_bit];
    en[src_timer1] = ien0_q[3];
    pend[src_i2c] = irq_request_flags_q[two_wire_request_flag_bit];
    en[src_i2c] = take_over[1] | ien1_q[i2c_enable_bit];
    pend[src_uart0] = uart0_irq_i;
    en[src_uart0] = ien0_q[4];
    pend[src_mac] = irq_request_flags_q[multiply_accumulate_flag_bit];
    en[src_mac] = take_over[2] | ien1_q[mac_enable_bit];
    pend[src_timer2] = irq_request_flags_q[timer2_overflow_flag_bit] |
                       irq_request_flags_q[timer2_reload_flag_bit];
    en[src_timer2] = ien0_q[5];
    pend[src_adc] = irq_request_flags_q[converter_request_flag_bit];
    en[src_adc] = take_over[3] | ien1_q[adc_enable_bit];
  end

  // group of each source: natural pairs share one priority bit
  // the second uart has its own case but still lands in group 0 with the
  // first external pin, the same group that pairing by index gives it
  genvar g;
  generate
    for (g = 0; g < num_src; g++) begin : g_lvl
      localparam int grp_idx = (g == src_uart1) ? 0 : (g / 2);
      // level is {high register bit, low register bit}
      assign lvl[g] = {ip1_q[grp_idx], ip0_q[grp_idx]};
    end
  endgenerate

  // highest level first, ties by natural order
  // a linear scan: twelve sources keep the path short enough, and
  // it was preferred over a tree for readability
  always_comb begin
    best_any = 1'b0;
    best_src = no_source;
    best_lvl = 2'b00;
    for (int i = 0; i < num_src; i++) begin
      if (pend[i] && en[i] && ien0_q[global_irq_gate_bit]) begin
        if (!best_any || lvl[i] > best_lvl) begin
          best_any = 1'b1;
          best_src = 4'(i);
          best_lvl = lvl[i];
        end
      end
    end
  end

  // nesting: a request is offered only above the running levels
  // one bit per level remembers which levels are in service; on
  // return the running level falls to the next lower active one
  // limitation: a core that returns out of order confuses the stack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_q <= 4'h0;
      run_lvl_q <= 2'b00;
    end else begin
      if (ack_i && req_q) begin
        active_q <= active_q | 4'(1 << top_lvl_q);
        run_lvl_q <= top_lvl_q;
      end else if (ret_i) begin
        active_q <= active_q & ~4'(1 << run_lvl_q);
        run_lvl_q <= active_q[2] && run_lvl_q == 2'd3 ? 2'd2 :
                     active_q[1] && run_lvl_q >= 2'd2 ? 2'd1 : 2'd0;
      end
    end
  end

  // registered request to the core
  // the request is withheld in the ack cycle so the core never sees
  // the serviced source offered twice before its flag has cleared
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q <= 1'b0;
      top_src_q <= no_source;
      top_lvl_q <= 2'b00;
    end else begin
      req_q <= best_any && !ack_i &&
               (active_q == 4'h0 || best_lvl > run_lvl_q);
      top_src_q <= best_src;
      top_lvl_q <= best_lvl;
    end
  end

  assign irq_o = req_q;
  assign irq_src_o = top_src_q;
  assign irq_level_o = top_lvl_q;
  assign timer_zero_run_o = timer_and_external_irq_control_q[timer_zero_run_bit];
  assign timer_one_run_o = timer_and_external_irq_control_q[timer_one_run_bit];

  // wishbone answer one cycle after the strobe; unmapped reads zero
  // ack blocks a second access in its own cycle, so a master that
  // holds stb through ack is answered once only
  // unmapped writes are acked and dropped, never a bus error
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_q <= access;
      dat_o <= 32'h0000_0000;
      if (access && !we_i) begin
        case (idx)
          timer_ctrl_idx: dat_o[7:0] <= timer_and_external_irq_control_q;
          req_flags_idx: dat_o[7:0] <= irq_request_flags_q;
          enable_zero_idx: dat_o[7:0] <= ien0_q;
          enable_one_idx: dat_o[7:0] <= ien1_q;
          enable_third_idx: dat_o[7:0] <= irq_enable_third_q;
          prio_low_idx: dat_o[7:0] <= ip0_q;
          prio_high_idx: dat_o[7:0] <= ip1_q;
          compare_cfg_idx: dat_o[7:0] <= compare_capture_enable_config_q;
          vector_idx: dat_o[7:0] <= {req_q, 1'b0, top_lvl_q, top_src_q};
          default: dat_o[7:0] <= 8'h00;
        endcase
      end
    end
  end
  assign ack_o = ack_q;
endmodule : irq_priority_ctrl

// [inc/irq_pkg.sv]
/*
  shared constants for the interrupt priority controller: register
  offsets, bit positions, reset values and the source numbering.
  assumes a byte-wide register file reached over classic wishbone.
*/
package irq_pkg;
  // printed offsets are not all multiples of four: index, byte address is 4x
  localparam logic [7:0] timer_ctrl_idx = 8'h88;
  localparam logic [7:0] req_flags_idx = 8'h91;
  localparam logic [7:0] enable_third_idx = 8'h9a;
  localparam logic [7:0] prio_low_idx = 8'hb8;
  localparam logic [7:0] prio_high_idx = 8'hb9;
  localparam logic [7:0] enable_zero_idx = 8'ha8;
  localparam logic [7:0] enable_one_idx = 8'he8;
  localparam logic [7:0] compare_cfg_idx = 8'hc1;
  localparam logic [7:0] vector_idx = 8'hc2;
  localparam logic [7:0] reg_reset = 8'h00;
  // first enable register fields
  localparam int global_irq_gate_bit = 7;
  // second enable register fields
  localparam int timer2_reload_irq_enable_bit = 7;
  localparam int adc_enable_bit = 5;
  localparam int mac_enable_bit = 4;
  localparam int i2c_enable_bit = 3;
  localparam int spi_receive_irq_enable_bit = 2;
  localparam int spi_transmit_empty_irq_enable_bit = 1;
  // third enable register
  localparam int second_uart_irq_enable_bit = 0;
  // request flag register fields
  localparam int timer2_reload_flag_bit = 7;
  localparam int timer2_overflow_flag_bit = 6;
  localparam int converter_request_flag_bit = 5;
  localparam int multiply_accumulate_flag_bit = 4;
  localparam int two_wire_request_flag_bit = 3;
  localparam int spi_receive_flag_bit = 2;
  localparam int spi_transmit_empty_flag_bit = 1;
  // priority register fields
  localparam int spare_storage_bit = 7;
  localparam int watchdog_overflow_status_bit = 6;
  // timer control fields
  localparam int timer_one_overflow_bit = 7;
  localparam int timer_one_run_bit = 6;
  localparam int timer_zero_overflow_bit = 5;
  localparam int timer_zero_run_bit = 4;
  localparam int external_irq_b_flag_bit = 3;
  localparam int external_irq_b_type_bit = 2;
  localparam int external_irq_a_flag_bit = 1;
  localparam int external_irq_a_type_bit = 0;
  // sources in natural order, index 0 wins ties
  localparam int num_src = 12;
  localparam int src_ext_a = 0;
  localparam int src_uart1 = 1;
  localparam int src_timer0 = 2;
  localparam int src_spi_tx = 3;
  localparam int src_ext_b = 4;
  localparam int src_spi_rx = 5;
  localparam int src_timer1 = 6;
  localparam int src_i2c = 7;
  localparam int src_uart0 = 8;
  localparam int src_mac = 9;
  localparam int src_timer2 = 10;
  localparam int src_adc = 11;
  localparam logic [3:0] no_source = 4'hf;
endpackage : irq_pkg

// [verif/irq_priority_ctrl_asserts.sv]
/*
  port checks for irq_priority_ctrl, bound at the foot of this file.
  assumes one clock, synchronous reset and a wishbone classic master.
*/
`timescale 1ns/1ps
module irq_ctrl_checker
  import irq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic ack_i,
  input wire logic irq_o,
  input wire logic timer_zero_run_o,
  input wire logic timer_one_run_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic gate_q;
  sequence req_s(logic w, logic [7:0] idx);
    cyc_i && stb_i && !ack_o && we_i == w && (!w || sel_i[0])
      && adr_i[9:2] == idx;
  endsequence
  // shadow of the global gate, since no register is visible here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_q <= 1'b0;
    end else if (cyc_i && stb_i && !ack_o && we_i && sel_i[0]
                 && adr_i[9:2] == enable_zero_idx) begin
      gate_q <= dat_i[global_irq_gate_bit];
    end
  end
  a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after a request");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_third_unused: assert property (req_s(1'b0, enable_third_idx)
    |=> dat_o[7:1] == 7'h0) else $error("third enable unused bits set");
  a_prio_unused: assert property (req_s(1'b0, prio_high_idx)
    |=> dat_o[7:6] == 2'h0) else $error("priority high bits 7:6 set");
  a_run_bits: assert property (req_s(1'b1, timer_ctrl_idx)
    |=> timer_zero_run_o == $past(dat_i[timer_zero_run_bit])
    && timer_one_run_o == $past(dat_i[timer_one_run_bit]))
    else $error("run outputs do not follow the written bits");
  a_gate_masks: assert property (!gate_q && !$past(gate_q)
    |-> !irq_o) else $error("request while the global gate is closed");
  a_ack_drops: assert property (irq_o && ack_i |=> !irq_o)
    else $error("request still raised after service");
endmodule : irq_ctrl_checker

bind irq_priority_ctrl irq_ctrl_checker chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .ack_i(ack_i), .irq_o(irq_o),
  .timer_zero_run_o(timer_zero_run_o), .timer_one_run_o(timer_one_run_o)
);

// [verif/core_model.sv]
/*
  behavioural processor core: takes a standing request after dly_i
  cycles, runs a short handler, then returns. assumes a shared clock.
*/
`timescale 1ns/1ps
module core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic irq_i,
  input wire logic en_i,
  input wire logic [2:0] dly_i,
  output logic ack_o,
  output logic ret_o
);
  logic [2:0] wait_q;
  logic [2:0] busy_q;
  // service pulse, only while the request still stands
  always_ff @(posedge clk_i) begin
    ack_o <= 1'b0;
    ret_o <= 1'b0;
    if (rst_i) begin
      wait_q <= 3'h0;
      busy_q <= 3'h0;
    end else if (busy_q != 3'h0) begin
      busy_q <= busy_q - 3'h1;
      ret_o <= busy_q == 3'h1;
    end else if (irq_i && en_i) begin
      wait_q <= wait_q + 3'h1;
      if (wait_q == dly_i) begin
        ack_o <= 1'b1;
        busy_q <= 3'h4;
        wait_q <= 3'h0;
      end
    end else begin
      wait_q <= 3'h0;
    end
  end
endmodule : core_model

// [verif/tb_interrupt_priority_control.sv]
/*
  self-checking bench for the interrupt priority controller.
  assumes irq_pkg, the core model and the bound port checker.
*/
`timescale 1ns/1ps
module tb_interrupt_priority_control
  import irq_pkg::*;
  ;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [9:0] adr_i = 10'h0;
  logic [31:0] dat_i = 32'h0;
  logic [15:0] ev = 16'h0;
  logic pin_a = 1'b1;
  logic pin_b = 1'b1;
  logic en = 1'b0;
  logic [31:0] dat_o;
  logic ack_o;
  logic ack_i;
  logic ret_i;
  logic irq_o;
  logic run0;
  logic run1;
  logic [3:0] irq_src_o;
  logic [1:0] irq_level_o;
  int miscompares = 0;
  int compares = 0;
  // one event vector, so a scenario can fire several sources at once
  irq_priority_ctrl dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o),
    .external_irq_a_pin_i(pin_a), .external_irq_b_pin_i(pin_b),
    .timer0_ovf_i(ev[0]), .timer1_ovf_i(ev[1]), .timer2_ovf_i(ev[2]),
    .timer2_reload_i(ev[3]), .uart0_irq_i(ev[4]), .uart1_irq_i(ev[5]),
    .spi_rx_i(ev[6]), .spi_tx_i(ev[7]), .i2c_i(ev[8]), .mac_ovf_i(ev[9]),
    .adc_i(ev[10]), .compare_i(ev[14:11]), .watchdog_ovf_i(ev[15]),
    .ack_i(ack_i), .ret_i(ret_i), .irq_o(irq_o), .irq_src_o(irq_src_o),
    .irq_level_o(irq_level_o), .timer_zero_run_o(run0),
    .timer_one_run_o(run1)
  );
  // core answers after two cycles of a standing request
  core_model core (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq_o),
    .en_i(en), .dly_i(3'h2), .ack_o(ack_i), .ret_o(ret_i));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  task automatic hang(input int n);
    if (n >= 16) begin
      miscompares++;
      end_sim();
    end
  endtask : hang
  task automatic chk(input logic [7:0] got, input logic [7:0] e);
    compares++;
    if (got !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, e);
    end
  endtask : chk
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] idx,
                    input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    hang(n);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, idx, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, idx, 8'h0, q);
    chk(q, e);
  endtask : rd
  task automatic pulse(input logic [15:0] m);
    ev <= m;
    @(posedge clk_i);
    ev <= 16'h0;
    @(posedge clk_i);
  endtask : pulse
  task automatic wait_irq(input logic [3:0] src, input logic [1:0] lvl);
    int n;
    n = 0;
    while (!(irq_o === 1'b1 && irq_src_o === src) && n < 16) begin
      @(posedge clk_i);
      n++;
    end
    hang(n);
    chk({6'h0, irq_level_o}, {6'h0, lvl});
  endtask : wait_irq
  // cleared after reset; unmapped space takes writes and reads zero
  task automatic t_reset();
    logic [7:0] tbl [6];
    tbl = '{timer_ctrl_idx, req_flags_idx, enable_third_idx,
            prio_low_idx, prio_high_idx, 8'h10};
    wr(8'h10, 8'hff);
    foreach (tbl[i]) begin
      rd(tbl[i], reg_reset);
    end
  endtask : t_reset
  // storage bits, unused bits and the sticky watchdog flag
  task automatic t_regs();
    wr(enable_third_idx, 8'hff);
    rd(enable_third_idx, 8'h01);
    wr(prio_high_idx, 8'hff);
    rd(prio_high_idx, 8'h3f);
    wr(prio_high_idx, 8'h00);
    wr(prio_low_idx, 8'h80);
    rd(prio_low_idx, 8'h80);
    pulse(16'h8000);
    rd(prio_low_idx, 8'hc0);
    rd(prio_low_idx, 8'hc0);
    wr(prio_low_idx, 8'h00);
    rd(prio_low_idx, 8'h00);
  endtask : t_regs
  task automatic t_timer();
    wr(timer_ctrl_idx, 8'h50);
    chk({6'h0, run1, run0}, 8'h03);
    pulse(16'h0003);
    rd(timer_ctrl_idx, 8'hf0);
    wr(timer_ctrl_idx, 8'h00);
    chk({6'h0, run1, run0}, 8'h00);
    rd(timer_ctrl_idx, 8'h00);
  endtask : t_timer
  // flag sets with the gate shut; request only once gate and enable agree
  task automatic t_spi();
    wr(enable_one_idx, 8'h02);
    pulse(16'h0080);
    rd(req_flags_idx, 8'h02);
    chk({7'h0, irq_o}, 8'h00);
    wr(enable_zero_idx, 8'h80);
    wait_irq(4'h3, 2'h0);
    wr(enable_one_idx, 8'h00);
    rd(req_flags_idx, 8'h02);
    chk({7'h0, irq_o}, 8'h00);
    wr(req_flags_idx, 8'h00);
    pulse(16'h0008);
    rd(req_flags_idx, 8'h00);
    wr(enable_one_idx, 8'h80);
    pulse(16'h0008);
    rd(req_flags_idx, 8'h80);
    wr(req_flags_idx, 8'h00);
    wr(enable_one_idx, 8'h00);
  endtask : t_spi
  // each compare unit takes only its own channel
  task automatic t_share();
    int per [4] = '{6, 8, 9, 10};
    wr(enable_one_idx, 8'h3c);
    for (int k = 0; k < 4; k++) begin
      wr(compare_cfg_idx, 8'h01 << (2 * k));
      pulse((16'h1 << per[k]) | (16'h1 << per[(k + 1) % 4]));
      rd(req_flags_idx, 8'h04 << ((k + 1) % 4));
      wr(req_flags_idx, 8'h00);
      pulse(16'h0800 << k);
      rd(req_flags_idx, 8'h04 << k);
      wr(req_flags_idx, 8'h00);
    end
    wr(compare_cfg_idx, 8'h00);
  endtask : t_share
  // natural order first, then levels 1 to 3 of one group, then a tie
  task automatic t_prio();
    wr(enable_one_idx, 8'h06);
    pulse(16'h00c0);
    wait_irq(4'h3, 2'h0);
    for (int l = 1; l < 4; l++) begin
      wr(prio_low_idx, {7'h0, l[0]} << 2);
      wr(prio_high_idx, {7'h0, l[1]} << 2);
      wait_irq(4'h5, l[1:0]);
    end
    wr(prio_low_idx, 8'h06);
    wr(prio_high_idx, 8'h06);
    wait_irq(4'h3, 2'h3);
    wr(prio_low_idx, 8'h00);
    wr(prio_high_idx, 8'h00);
    wr(req_flags_idx, 8'h00);
    wr(enable_one_idx, 8'h00);
  endtask : t_prio
  // edge pin serviced by the core, then a level pin; sync takes 3 cycles
  task automatic t_ext();
    wr(timer_ctrl_idx, 8'h01);
    wr(enable_zero_idx, 8'h81);
    en <= 1'b1;
    pin_a <= 1'b0;
    wait_irq(4'h0, 2'h0);
    repeat (8) @(posedge clk_i);
    rd(timer_ctrl_idx, 8'h01);
    chk({7'h0, irq_o}, 8'h00);
    en <= 1'b0;
    pin_a <= 1'b1;
    wr(timer_ctrl_idx, 8'h00);
    pin_b <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(timer_ctrl_idx, 8'h08);
    wr(enable_zero_idx, 8'h84);
    wait_irq(4'h4, 2'h0);
    pin_b <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(timer_ctrl_idx, 8'h00);
  endtask : t_ext
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_regs();
    t_timer();
    t_spi();
    t_share();
    t_prio();
    t_ext();
    end_sim();
  end
endmodule : tb_interrupt_priority_control
